// File: bank_port_ctrl.sv
// One memory port sequencer: issue, wait-state tracking, error capture, ECC.
// Assumes the memory holds ready low to insert waits and pulses error with ready.
`timescale 1ns/10ps
module bank_port_ctrl
  import tight_memory_pkg::*;
#(
  parameter bit ECC_EN = 1'b0
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // Access from the decoder
  input wire logic start_in,
  input wire logic write_in,
  input wire logic [21:0] index_in,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] strobe_in,
  // Memory side
  output mem_req_s mem_out,
  input wire mem_rsp_s mem_in,
  // Completion
  output logic done_out,
  output logic fault_out,
  output logic [31:0] rdata_out
);

  port_state_e state_reg;
  mem_req_s req_reg;
  logic done_reg;
  logic fault_reg;
  logic [31:0] rdata_reg;
  logic ecc_bad;
  logic [ECC_W-1:0] syndrome;

  assign mem_out = req_reg;
  assign done_out = done_reg;
  assign fault_out = fault_reg;
  assign rdata_out = rdata_reg;

  // Syndrome check; correction is left to memory scrub, double errors fault
  always_comb begin
    syndrome = ecc_encode(mem_in.rdata) ^ mem_in.rcheck;
    ecc_bad = ECC_EN && !req_reg.write && (syndrome != '0) && !syndrome[ECC_W-1];
  end

  // Port sequencer: hold request until memory drops its wait
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg <= ST_IDLE;
      req_reg <= '0;
      done_reg <= 1'b0;
      fault_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      done_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (start_in) begin
            req_reg.req <= 1'b1;
            req_reg.write <= write_in;
            req_reg.index <= index_in;
            req_reg.wdata <= wdata_in;
            req_reg.strobe <= strobe_in;
            req_reg.wcheck <= ECC_EN ? ecc_encode(wdata_in) : '0;
            state_reg <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (mem_in.ready) begin
            req_reg.req <= 1'b0;
            done_reg <= 1'b1;
            fault_reg <= mem_in.error || ecc_bad;
            rdata_reg <= mem_in.rdata;
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// File: test_tight_memory_port_decode.sv
// Self-checking bench for the tight memory decoder with three bank models.
// Assumes straps stay fixed after reset and one access is open at a time.
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module test_tight_memory_port_decode
  import tight_memory_pkg::*;
  ;
  typedef struct packed {logic to_main; logic fault; logic abort; logic chk; logic [31:0] data;} note_s;
  // Straps: fixed for the whole run, as only a cold reset may change them
  logic core_clk_in = 1'b0, nrst_in = 1'b0, instr_enable_init_in = 1'b1, data_enable_init_in = 1'b1;
  logic [SIZE_CODE_W-1:0] instr_size_log2_in = 5'h0a, data_size_log2_in = 5'h0c;
  logic [1:0] alias_bit_select_in = 2'h1, instance_base_select_in = 2'h1;
  logic nonsecure_fault_priority_bit_in = 1'b0;
  logic ctrl_wr_in = 1'b0, ctrl_sel_data_in = 1'b0, ctrl_wdata_in = 1'b0, ctrl_priv_in = 1'b1;
  logic ctrl_nonsecure_in = 1'b0, cpu_req_in = 1'b0, cpu_write_in = 1'b0, cpu_committed_in = 1'b1;
  logic cpu_perm_ok_in = 1'b1, err = 1'b0;
  logic [31:0] cpu_addr_in = 32'h0, cpu_wdata_in = 32'h0, cpu_rdata_out, rel;
  logic [3:0] cpu_strobe_in = 4'hf;
  logic [1:0] wt = 2'h0;
  mem_req_s instr_tight_memory_out, data_bank_even_port_out, data_bank_odd_port_out;
  mem_rsp_s instr_tight_memory_in, data_bank_even_port_in, data_bank_odd_port_in;
  logic ctrl_rdata_out, cpu_done_out, cpu_fault_out, cpu_abort_out, cpu_to_main_out;
  int n_fail = 0, checked = 0;
  note_s notes[$];
  logic [31:0] mirror [int];

  tight_memory_port_decode dut (.core_clk_in, .nrst_in, .instr_size_log2_in, .data_size_log2_in,
    .instr_enable_init_in, .data_enable_init_in, .alias_bit_select_in, .instance_base_select_in,
    .nonsecure_fault_priority_bit_in, .ctrl_wr_in, .ctrl_sel_data_in, .ctrl_wdata_in, .ctrl_priv_in,
    .ctrl_nonsecure_in, .cpu_req_in, .cpu_write_in, .cpu_committed_in, .cpu_perm_ok_in, .cpu_addr_in,
    .cpu_wdata_in, .cpu_strobe_in, .instr_tight_memory_out, .instr_tight_memory_in, .data_bank_even_port_out,
    .data_bank_even_port_in, .data_bank_odd_port_out, .data_bank_odd_port_in, .ctrl_rdata_out,
    .cpu_done_out, .cpu_fault_out, .cpu_abort_out, .cpu_to_main_out, .cpu_rdata_out);
  tight_memory_model #(.PORT_ID(4'h1)) m_i (.core_clk_in, .nrst_in, .mem_in(instr_tight_memory_out),
    .mem_out(instr_tight_memory_in), .wait_cycles_in(wt), .err_in(1'b0));
  tight_memory_model #(.PORT_ID(4'h2)) m_e (.core_clk_in, .nrst_in, .mem_in(data_bank_even_port_out),
    .mem_out(data_bank_even_port_in), .wait_cycles_in(wt), .err_in(err));
  tight_memory_model #(.PORT_ID(4'h3)) m_o (.core_clk_in, .nrst_in, .mem_in(data_bank_odd_port_out),
    .mem_out(data_bank_odd_port_in), .wait_cycles_in(wt), .err_in(1'b0));

  // 125 MHz core clock
  initial forever #4 core_clk_in = ~core_clk_in;

  // Expected word location: port id over index, matching unwritten contents
  function automatic logic [31:0] key(input logic [31:0] a);
    if (a[31:29] == REGION_TOP_CODE) begin
      return {4'h1, 6'h0, a[23:2]};
    end
    return {a[2] ? 4'h3 : 4'h2, 7'h0, a[23:3]};
  endfunction

  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Bounded wait for completion; a hang ends the run
  task automatic wait_done();
    int i;
    for (i = 0; i < 40 && cpu_done_out !== 1'b1; i++) begin
      @(negedge core_clk_in);
    end
    if (i == 40) begin
      n_fail++;
      close_out();
    end
  endtask

  task automatic rd(input logic [31:0] a, input logic pm, input logic mn, input logic fl);
    note_s n;
    n.to_main = mn;
    n.fault = fl;
    n.abort = !pm && !mn;
    n.chk = pm && !mn && !fl;
    n.data = mirror.exists(key(a)) ? mirror[key(a)] : key(a);
    notes.push_back(n);
    @(negedge core_clk_in);
    cpu_addr_in = a;
    cpu_perm_ok_in = pm;
    cpu_write_in = 1'b0;
    cpu_req_in = 1'b1;
    wait_done();
    cpu_req_in = 1'b0;
  endtask

  // Committed writes complete silently into the buffer in one cycle; uncommitted ones are dropped
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic cm);
    @(negedge core_clk_in);
    cpu_addr_in = a;
    cpu_wdata_in = d;
    cpu_write_in = 1'b1;
    cpu_committed_in = cm;
    cpu_req_in = 1'b1;
    @(negedge core_clk_in);
    cpu_req_in = 1'b0;
    cpu_committed_in = 1'b1;
    if (cm) begin
      mirror[key(a)] = d;
    end
  endtask

  task automatic ctl(input logic sel, input logic d, input logic pv, input logic ns, input logic ex);
    @(negedge core_clk_in);
    ctrl_sel_data_in = sel;
    ctrl_wdata_in = d;
    ctrl_priv_in = pv;
    ctrl_nonsecure_in = ns;
    ctrl_wr_in = 1'b1;
    @(negedge core_clk_in);
    ctrl_wr_in = 1'b0;
    ctrl_priv_in = 1'b1;
    ctrl_nonsecure_in = 1'b0;
    repeat (2) @(negedge core_clk_in);
    `CHK(ctrl_rdata_out, ex)
  endtask

  // Result watcher: oldest note against each completion
  initial begin
    note_s n;
    forever begin
      @(negedge core_clk_in);
      if (cpu_done_out === 1'b1) begin
        `CHK(notes.size() > 0, 1'b1)
        n = notes.pop_front();
        `CHK(cpu_to_main_out, n.to_main)
        `CHK(cpu_fault_out, n.fault)
        `CHK(cpu_abort_out, n.abort)
        if (n.chk) `CHK(cpu_rdata_out, n.data)
      end
    end
  end

  initial begin
    logic [31:0] r, a;
    void'($urandom(32'h8723));
    repeat (10) @(negedge core_clk_in);
    nrst_in = 1'b1;
    repeat (2) @(negedge core_clk_in);
    rel = {6'h0, instance_base_select_in, 24'h00_0000};
    `CHK(ctrl_rdata_out, 1'b1)
    for (int i = 0; i < 16; i++) begin
      r = $urandom;
      wt = r[13:12];
      a = r[0] ? (DATA_BASE | rel | {20'h0, r[11:2], 2'h0}) : (INSTR_BASE | rel | {22'h0, r[9:2], 2'h0});
      rd(a, 1'b1, 1'b0, 1'b0);
    end
    wt = 2'h3;
    a = DATA_BASE | rel | 32'h0000_0020;
    wr(a, $urandom, 1'b1);
    rd(a, 1'b1, 1'b0, 1'b0);
    rd(a | 32'h0800_0000, 1'b1, 1'b0, 1'b0);
    wr(a + 4, $urandom, 1'b0);
    rd(a + 4, 1'b1, 1'b0, 1'b0);
    rd(DATA_BASE | rel | 32'h0000_1000, 1'b1, 1'b1, 1'b0);
    rd(INSTR_BASE | rel | 32'h0000_0400, 1'b1, 1'b1, 1'b0);
    rd(DATA_BASE | rel | 32'h0400_0000, 1'b1, 1'b1, 1'b0);
    err = 1'b1;
    rd(DATA_BASE | rel, 1'b1, 1'b0, 1'b1);
    err = 1'b0;
    rd(INSTR_BASE | rel | 32'h4, 1'b0, 1'b0, 1'b0);
    ctl(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    rd(DATA_BASE | rel | 32'h10, 1'b1, 1'b1, 1'b0);
    ctl(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    ctl(1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
    ctl(1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
    ctrl_nonsecure_in = 1'b1;
    repeat (2) @(negedge core_clk_in);
    `CHK(ctrl_rdata_out, 1'b0)
    ctrl_nonsecure_in = 1'b0;
    rd(INSTR_BASE | rel | 32'h8, 1'b1, 1'b0, 1'b0);
    repeat (4) @(negedge core_clk_in);
    `CHK(notes.size(), 0)
    close_out();
  end
endmodule

// File: tight_memory_model.sv
// Behavioural memory bank behind one port: word store, wait states, error on demand.
// Assumes the port holds its request until ready is seen.
`timescale 1ns/10ps
module tight_memory_model
  import tight_memory_pkg::*;
#(
  parameter logic [3:0] PORT_ID = 4'h0
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // Port
  input wire mem_req_s mem_in,
  output mem_rsp_s mem_out,
  // Test controls
  input wire logic [1:0] wait_cycles_in,
  input wire logic err_in
);
  logic [31:0] store [int];
  logic [31:0] word;
  int cnt;

  // Unwritten words read as port id and index, so a wrong bank shows
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mem_out <= '0;
      cnt <= 0;
    end else if (mem_in.req && !mem_out.ready && cnt >= wait_cycles_in) begin
      word = store.exists(mem_in.index) ? store[mem_in.index] : {PORT_ID, 6'h0, mem_in.index};
      for (int b = 0; b < 4; b++) begin
        if (mem_in.write && mem_in.strobe[b]) begin
          word[8*b +: 8] = mem_in.wdata[8*b +: 8];
        end
      end
      if (mem_in.write) begin
        store[mem_in.index] = word;
      end
      mem_out.rdata <= word;
      mem_out.ready <= 1'b1;
      mem_out.error <= err_in;
      cnt <= 0;
    end else begin
      // Data lines toggle when not answering, so stale reads cannot pass
      mem_out.rdata <= ~mem_out.rdata;
      mem_out.ready <= 1'b0;
      mem_out.error <= 1'b0;
      cnt <= mem_in.req ? cnt + 1 : 0;
    end
  end
endmodule

// File: tight_memory_pkg.sv
// Constants, types and field layouts for the tight memory port decoder.
// Assumes a single 125 MHz core clock and an active-low asynchronous reset.
package tight_memory_pkg;

  localparam logic [31:0] INSTR_BASE = 32'h0000_0000;
  localparam logic [31:0] DATA_BASE = 32'h2000_0000;
  localparam logic [2:0] REGION_TOP_CODE = 3'h0;
  localparam logic [2:0] REGION_TOP_SRAM = 3'h1;
  localparam int REGION_TOP_LSB = 29;
  localparam int INST_SEL_LSB = 24;
  localparam int BANK_SEL_BIT = 2;
  localparam int ALIAS_LSB_MIN = 26;
  localparam int MAX_SIZE_LOG2 = 24;
  localparam int SIZE_CODE_W = 5;
  localparam int ECC_W = 7;
  localparam logic CTRL_ENABLE_RESET = 1'b0;

  // Memory port request toward an SRAM bank
  typedef struct packed {
    logic req;
    logic write;
    logic [21:0] index;
    logic [31:0] wdata;
    logic [3:0] strobe;
    logic [ECC_W-1:0] wcheck;
  } mem_req_s;

  // Memory port response from an SRAM bank
  typedef struct packed {
    logic ready;
    logic error;
    logic [31:0] rdata;
    logic [ECC_W-1:0] rcheck;
  } mem_rsp_s;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ISSUE = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_DONE = 4'b1000
  } port_state_e;

  // Check bits for a word: parity over index-masked bit groups
  function automatic logic [ECC_W-1:0] ecc_encode(input logic [31:0] d);
    logic [ECC_W-1:0] c;
    int pos;
    c = '0;
    pos = 3;
    for (int i = 0; i < 32; i++) begin
      while ((pos & (pos - 1)) == 0) begin
        pos++;
      end
      for (int b = 0; b < ECC_W - 1; b++) begin
        if (pos[b]) begin
          c[b] = c[b] ^ d[i];
        end
      end
      c[ECC_W-1] = c[ECC_W-1] ^ d[i];
      pos++;
    end
    for (int b = 0; b < ECC_W - 1; b++) begin
      c[ECC_W-1] = c[ECC_W-1] ^ c[b];
    end
    return c;
  endfunction

endpackage

// File: tight_memory_port_decode.sv
// Top of the tight memory decoder: region decode, alias, relocation,
// write buffer with read hazard, fallback to the main bus.
// Assumes the core presents one access at a time and holds it until done.
`timescale 1ns/10ps
module tight_memory_port_decode
  import tight_memory_pkg::*;
#(
  parameter bit ECC_EN = 1'b0,
  parameter bit SECURITY_EXT = 1'b1
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // Cold reset configuration
  input wire logic [SIZE_CODE_W-1:0] instr_size_log2_in,
  input wire logic [SIZE_CODE_W-1:0] data_size_log2_in,
  input wire logic instr_enable_init_in,
  input wire logic data_enable_init_in,
  input wire logic [1:0] alias_bit_select_in,
  input wire logic [1:0] instance_base_select_in,
  input wire logic nonsecure_fault_priority_bit_in,
  // Control register access
  input wire logic ctrl_wr_in,
  input wire logic ctrl_sel_data_in,
  input wire logic ctrl_wdata_in,
  input wire logic ctrl_priv_in,
  input wire logic ctrl_nonsecure_in,
  // Processor access
  input wire logic cpu_req_in,
  input wire logic cpu_write_in,
  input wire logic cpu_committed_in,
  input wire logic cpu_perm_ok_in,
  input wire logic [31:0] cpu_addr_in,
  input wire logic [31:0] cpu_wdata_in,
  input wire logic [3:0] cpu_strobe_in,
  // Memory ports
  output mem_req_s instr_tight_memory_out,
  input wire mem_rsp_s instr_tight_memory_in,
  output mem_req_s data_bank_even_port_out,
  input wire mem_rsp_s data_bank_even_port_in,
  output mem_req_s data_bank_odd_port_out,
  input wire mem_rsp_s data_bank_odd_port_in,
  // Results
  output logic ctrl_rdata_out,
  output logic cpu_done_out,
  output logic cpu_fault_out,
  output logic cpu_abort_out,
  output logic cpu_to_main_out,
  output logic [31:0] cpu_rdata_out
);

  // Alias bit climbs at most two places above its lowest position
  if (ALIAS_LSB_MIN + 2 > 28) begin : g_alias_range
    $error("alias bit range unsupported");
  end

  // Size code must be able to express the largest memory
  if ((1 << SIZE_CODE_W) <= MAX_SIZE_LOG2) begin : g_size_code
    $error("size code too narrow");
  end

  logic [SIZE_CODE_W-1:0] instr_size_reg;
  logic [SIZE_CODE_W-1:0] data_size_reg;
  logic [1:0] alias_sel_reg;
  logic [1:0] inst_sel_reg;
  logic cfg_loaded_reg;
  logic instr_en_reg;
  logic data_en_reg;
  logic ctrl_rdata_reg;
  logic busy_reg;
  logic pend_valid_reg;
  logic [31:0] pend_addr_reg;
  logic [31:0] pend_data_reg;
  logic [3:0] pend_strobe_reg;
  logic [2:0] port_sel_reg;
  logic done_reg;
  logic fault_reg;
  logic abort_reg;
  logic main_reg;
  logic [31:0] rdata_reg;
  logic perm_ok_reg;
  logic cur_write_reg;
  logic port_finish;

  // Strip the alias bit so both alias views map the same memory
  function automatic logic [31:0] strip_alias(input logic [31:0] a, input logic [1:0] sel);
    logic [31:0] r;
    r = a;
    r[ALIAS_LSB_MIN + int'(sel)] = 1'b0;
    return r;
  endfunction

  // Region hit: top bits, instance bits, offset below configured size
  function automatic logic region_hit(input logic [31:0] a, input logic [2:0] top,
                                      input logic [1:0] inst, input logic [SIZE_CODE_W-1:0] sz);
    logic [23:0] limit_mask;
    limit_mask = ~((24'h00_0001 << sz) - 24'h00_0001);
    return (a[31:REGION_TOP_LSB] == top) && (a[25:INST_SEL_LSB] == inst)
           && (a[REGION_TOP_LSB-1:ALIAS_LSB_MIN] == 3'h0)
           && (sz <= SIZE_CODE_W'(MAX_SIZE_LOG2)) && ((a[23:0] & limit_mask) == 24'h00_0000);
  endfunction

  logic [31:0] req_addr;
  logic hit_instr;
  logic hit_data;
  logic use_instr;
  logic use_data;
  logic [31:0] eff_addr;
  logic eff_write;
  logic drain_now;
  logic hazard;
  logic ctrl_blocked;

  // Decode of the current access; pending write drains before any new access
  always_comb begin
    drain_now = pend_valid_reg && !busy_reg;
    eff_addr = drain_now ? pend_addr_reg : cpu_addr_in;
    eff_write = drain_now;
    req_addr = strip_alias(eff_addr, alias_sel_reg);
    hit_instr = region_hit(req_addr, REGION_TOP_CODE, inst_sel_reg, instr_size_reg);
    hit_data = region_hit(req_addr, REGION_TOP_SRAM, inst_sel_reg, data_size_reg);
    use_instr = hit_instr && instr_en_reg;
    use_data = hit_data && data_en_reg;
    hazard = pend_valid_reg && (strip_alias(pend_addr_reg, alias_sel_reg) == strip_alias(cpu_addr_in, alias_sel_reg));
    ctrl_blocked = !ctrl_priv_in || (SECURITY_EXT && ctrl_nonsecure_in && !nonsecure_fault_priority_bit_in);
  end

  logic [2:0] port_start;
  logic [2:0] port_done;
  logic [2:0] port_fault;
  logic [31:0] port_rdata [3];
  mem_req_s port_req [3];
  mem_rsp_s port_rsp [3];
  logic start_any;

  // Bank choice: fixed by address bit 2, no software input reaches it
  always_comb begin
    port_start = 3'b000;
    start_any = !busy_reg && (drain_now || (cpu_req_in && !cpu_write_in && !hazard));
    if (start_any && use_instr) begin
      port_start = 3'b001;
    end else if (start_any && use_data) begin
      port_start = req_addr[BANK_SEL_BIT] ? 3'b100 : 3'b010;
    end
  end

  assign port_rsp[0] = instr_tight_memory_in;
  assign port_rsp[1] = data_bank_even_port_in;
  assign port_rsp[2] = data_bank_odd_port_in;
  assign instr_tight_memory_out = port_req[0];
  assign data_bank_even_port_out = port_req[1];
  assign data_bank_odd_port_out = port_req[2];

  // Three identical sequencers; instruction port indexes words, banks double words
  for (genvar p = 0; p < 3; p++) begin : g_port
    bank_port_ctrl #(
      .ECC_EN(ECC_EN)
    ) u_port (
      .core_clk_in(core_clk_in),
      .nrst_in(nrst_in),
      .start_in(port_start[p]),
      .write_in(eff_write),
      .index_in(p == 0 ? req_addr[23:2] : {1'b0, req_addr[23:3]}),
      .wdata_in(pend_data_reg),
      .strobe_in(pend_strobe_reg),
      .mem_out(port_req[p]),
      .mem_in(port_rsp[p]),
      .done_out(port_done[p]),
      .fault_out(port_fault[p]),
      .rdata_out(port_rdata[p])
    );
  end

  // The selected port has answered the access in flight
  assign port_finish = busy_reg && |(port_done & port_sel_reg);

  // Cold reset configuration capture after release
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cfg_loaded_reg <= 1'b0;
      instr_size_reg <= '0;
      data_size_reg <= '0;
      alias_sel_reg <= 2'h0;
      inst_sel_reg <= 2'h0;
    end else if (!cfg_loaded_reg) begin
      cfg_loaded_reg <= 1'b1;
      instr_size_reg <= instr_size_log2_in;
      data_size_reg <= data_size_log2_in;
      alias_sel_reg <= alias_bit_select_in;
      inst_sel_reg <= instance_base_select_in;
    end
  end

  // Enable state: strapped at release, changed by privileged writes only
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      instr_en_reg <= CTRL_ENABLE_RESET;
      data_en_reg <= CTRL_ENABLE_RESET;
    end else begin
      if (!cfg_loaded_reg) begin
        instr_en_reg <= instr_enable_init_in;
        data_en_reg <= data_enable_init_in;
      end else if (ctrl_wr_in && !ctrl_blocked) begin
        if (ctrl_sel_data_in) begin
          data_en_reg <= ctrl_wdata_in;
        end else begin
          instr_en_reg <= ctrl_wdata_in;
        end
      end
    end
  end

  // Control read-back: selected enable one cycle later, zero when blocked
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl_rdata_reg <= 1'b0;
    end else begin
      ctrl_rdata_reg <= ctrl_blocked ? 1'b0 : (ctrl_sel_data_in ? data_en_reg : instr_en_reg);
    end
  end

  // Only a committed store may enter; the buffer takes one at a time
  logic buf_accept;
  assign buf_accept = !pend_valid_reg && !busy_reg && cpu_req_in && cpu_write_in && cpu_committed_in
                      && cfg_loaded_reg;

  // One-entry write buffer flag; a drain toward the main bus just drops it
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pend_valid_reg <= 1'b0;
    end else if (drain_now && port_start == 3'b000) begin
      pend_valid_reg <= 1'b0;
    end else if (port_finish && cur_write_reg) begin
      pend_valid_reg <= 1'b0;
    end else if (buf_accept) begin
      pend_valid_reg <= 1'b1;
    end
  end

  // Buffered store contents, captured together with the flag
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pend_addr_reg <= 32'h0000_0000;
      pend_data_reg <= 32'h0000_0000;
      pend_strobe_reg <= 4'h0;
    end else if (buf_accept) begin
      pend_addr_reg <= cpu_addr_in;
      pend_data_reg <= cpu_wdata_in;
      pend_strobe_reg <= cpu_strobe_in;
    end
  end

  // Port occupancy: one access in flight, remembered with its kind
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      busy_reg <= 1'b0;
      port_sel_reg <= 3'b000;
      cur_write_reg <= 1'b0;
      perm_ok_reg <= 1'b0;
    end else if (!busy_reg && start_any && port_start != 3'b000) begin
      busy_reg <= 1'b1;
      port_sel_reg <= port_start;
      cur_write_reg <= drain_now;
      perm_ok_reg <= drain_now || cpu_perm_ok_in;
    end else if (port_finish) begin
      busy_reg <= 1'b0;
      port_sel_reg <= 3'b000;
    end
  end

  // Answer to the core; a store gets no answer, neither when it is buffered nor when it drains
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      done_reg <= 1'b0;
      fault_reg <= 1'b0;
      abort_reg <= 1'b0;
      main_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      done_reg <= 1'b0;
      main_reg <= 1'b0;
      if (!busy_reg && start_any && port_start == 3'b000 && !drain_now) begin
        main_reg <= 1'b1;
        done_reg <= 1'b1;
        fault_reg <= 1'b0;
        abort_reg <= 1'b0;
      end else if (port_finish && !cur_write_reg) begin
        done_reg <= 1'b1;
        fault_reg <= |(port_fault & port_sel_reg);
        // Read went out early; a late permission refusal becomes an abort
        abort_reg <= !perm_ok_reg || !cpu_perm_ok_in;
        rdata_reg <= port_sel_reg[0] ? port_rdata[0] : (port_sel_reg[1] ? port_rdata[1] : port_rdata[2]);
      end
    end
  end

  assign ctrl_rdata_out = ctrl_rdata_reg;
  assign cpu_done_out = done_reg;
  assign cpu_fault_out = fault_reg;
  assign cpu_abort_out = abort_reg;
  assign cpu_to_main_out = main_reg;
  assign cpu_rdata_out = rdata_reg;

endmodule

// File: tight_memory_port_decode_properties.sv
// Timing checks on the decoder's memory ports, completion and control read-back.
// Assumes it is bound to the decoder top and sees only its ports.
`timescale 1ns/10ps
module tight_memory_port_decode_properties
  import tight_memory_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // Memory ports
  input mem_req_s instr_tight_memory_out,
  input mem_req_s data_bank_even_port_out,
  input mem_rsp_s data_bank_even_port_in,
  input mem_req_s data_bank_odd_port_out,
  // Processor side and control
  input wire logic [31:0] cpu_addr_in,
  input wire logic ctrl_nonsecure_in,
  input wire logic nonsecure_fault_priority_bit_in,
  input wire logic ctrl_rdata_out,
  input wire logic cpu_done_out,
  input wire logic cpu_fault_out,
  input wire logic cpu_to_main_out
);
  // All checks share one clock; reset masks them
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  // Request, index and completion behaviour of the ports, and control read-back
  req_hold_a: assert property (data_bank_even_port_out.req && !data_bank_even_port_in.ready
    |=> data_bank_even_port_out.req && $stable(data_bank_even_port_out.index)) else $error("request dropped early");
  done_after_ready_a: assert property (data_bank_even_port_out.req && data_bank_even_port_in.ready
    && !data_bank_even_port_out.write |=> ##1 cpu_done_out) else $error("no done after ready");
  error_fault_a: assert property (data_bank_even_port_out.req && data_bank_even_port_in.ready
    && data_bank_even_port_in.error && !data_bank_even_port_out.write |=> ##1 cpu_fault_out) else $error("error lost");
  even_bank_a: assert property ($rose(data_bank_even_port_out.req) && !data_bank_even_port_out.write
    |-> !cpu_addr_in[2] && data_bank_even_port_out.index == {1'b0, cpu_addr_in[23:3]}) else $error("even bank wrong");
  odd_bank_a: assert property ($rose(data_bank_odd_port_out.req) && !data_bank_odd_port_out.write
    |-> cpu_addr_in[2] && data_bank_odd_port_out.index == {1'b0, cpu_addr_in[23:3]}) else $error("odd bank wrong");
  instr_index_a: assert property ($rose(instr_tight_memory_out.req) && !instr_tight_memory_out.write
    |-> instr_tight_memory_out.index == cpu_addr_in[23:2]) else $error("instruction index wrong");
  one_port_a: assert property ($onehot0({instr_tight_memory_out.req, data_bank_even_port_out.req,
    data_bank_odd_port_out.req})) else $error("two ports busy");
  main_done_a: assert property (cpu_to_main_out |-> cpu_done_out ##1 !cpu_done_out)
    else $error("main fallback without done");
  ns_block_a: assert property (ctrl_nonsecure_in && !nonsecure_fault_priority_bit_in |=> !ctrl_rdata_out)
    else $error("nonsecure read not zero");

  // Main scenarios reached
  cover property (data_bank_odd_port_out.req && !data_bank_odd_port_out.write);
  cover property (cpu_to_main_out);
  cover property (cpu_fault_out && cpu_done_out);
endmodule

bind tight_memory_port_decode tight_memory_port_decode_properties chk (.core_clk_in, .nrst_in,
  .instr_tight_memory_out, .data_bank_even_port_out, .data_bank_even_port_in, .data_bank_odd_port_out,
  .cpu_addr_in, .ctrl_nonsecure_in, .nonsecure_fault_priority_bit_in, .ctrl_rdata_out, .cpu_done_out,
  .cpu_fault_out, .cpu_to_main_out);
